// ===== rtl/mac_regs.vh
`ifndef MAC_REGS_VH
`define MAC_REGS_VH

// ********************************************************
// register offsets (6-bit serial address)
// ********************************************************
`define MAC_ADDR_DIAG_EN1    6'h0b
`define MAC_ADDR_PWM_SETUP   6'h20
`define MAC_ADDR_DIAG_SEL    6'h21
`define MAC_ADDR_PEAK_AB     6'h23
`define MAC_ADDR_ALPHA_CTRL  6'h24
`define MAC_ADDR_PEAK_CD     6'h28
`define MAC_ADDR_BETA_CTRL   6'h29
`define MAC_ADDR_DC_BRIDGE   6'h2c

// ********************************************************
// field positions
// ********************************************************
`define MAC_DIAG_EN_BIT      7
`define MAC_DIAG_SEL_MSB     4
`define MAC_SCALE_MSB        4
`define MAC_RES_LSB          5
`define MAC_LAMP_BIT         11
`define MAC_OUT_EN_BIT       10
`define MAC_DIR_BIT          8
`define MAC_STEPS_MSB        7
`define MAC_SRC_SEL_BIT      2
`define MAC_CTL_FIRST_BIT    1
`define MAC_CTL_SECOND_BIT   0

// ********************************************************
// reset values
// ********************************************************
`define MAC_RST_WORD         16'h0000

// ********************************************************
// diagnostic selections
// ********************************************************
`define MAC_DIAG_NORMAL      5'h00
`define MAC_DIAG_ENABLE      5'h03
`define MAC_DIAG_DIR         5'h04
`define MAC_DIAG_STEP_MON    5'h05
`define MAC_DIAG_PWM_MON     5'h06
`define MAC_DIAG_BUSY        5'h07

// ********************************************************
// serial frame: 3 command bits, 6 address bits, 16 data bits
// ********************************************************
`define MAC_FRAME_LAST       5'd24
`define MAC_HEAD_LAST        5'd8
`define MAC_CMD_WRITE        3'h0
`define MAC_CMD_READ         3'h1
`define MAC_PWM_UNIT         3'd3

`endif

// ===== rtl/mac_serial.v
`timescale 1ns/1ps
`include "mac_regs.vh"

module mac_serial (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        logic_rst,
  input  wire        chip_select,
  input  wire        serial_clock,
  input  wire        serial_in,
  output wire        serial_out,
  output reg  [5:0]  rd_addr_r,
  input  wire [15:0] rd_data,
  output reg         wr_strobe_r,
  output reg  [5:0]  wr_addr_r,
  output reg  [15:0] wr_data_r
);

  reg        sck_m_r;
  reg        sck_s_r;
  reg        sck_d_r;
  reg        cs_m_r;
  reg        cs_s_r;
  reg        sin_m_r;
  reg        sin_s_r;
  reg [4:0]  cnt_r;
  reg [23:0] shift_r;
  reg [15:0] out_r;
  reg        load_r;
  wire [24:0] frame_nxt;
  wire       sck_rise;
  wire       sck_fall;

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      cs_m_r  <= 1'b0;
      cs_s_r  <= 1'b0;
      sin_m_r <= 1'b0;
      sin_s_r <= 1'b0;
    end else begin
      sck_m_r <= serial_clock;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      cs_m_r  <= chip_select;
      cs_s_r  <= cs_m_r;
      sin_m_r <= serial_in;
      sin_s_r <= sin_m_r;
    end
  end

  assign sck_rise  = sck_s_r & ~sck_d_r;
  assign sck_fall  = ~sck_s_r & sck_d_r;
  assign frame_nxt = {shift_r, sin_s_r};
  assign serial_out = out_r[15];

  // ********************************************************
  // frame shifter, write strobe and read load
  // ********************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r       <= 5'd0;
      shift_r     <= 24'h000000;
      out_r       <= 16'h0000;
      load_r      <= 1'b0;
      rd_addr_r   <= 6'h00;
      wr_strobe_r <= 1'b0;
      wr_addr_r   <= 6'h00;
      wr_data_r   <= 16'h0000;
    end else begin
      wr_strobe_r <= 1'b0;
      load_r      <= 1'b0;
      if (load_r)
        out_r <= rd_data;                     // read word fetched one cycle after address
      if (logic_rst || !cs_s_r) begin
        cnt_r <= 5'd0;
      end else if (sck_rise) begin
        shift_r <= frame_nxt[23:0];
        cnt_r   <= cnt_r + 5'd1;
        if (cnt_r == `MAC_HEAD_LAST && frame_nxt[8:6] == `MAC_CMD_READ) begin
          rd_addr_r <= frame_nxt[5:0];
          load_r    <= 1'b1;
        end
        // write only once all 25 bits are in
        if (cnt_r == `MAC_FRAME_LAST && frame_nxt[24:22] == `MAC_CMD_WRITE) begin
          wr_strobe_r <= 1'b1;
          wr_addr_r   <= frame_nxt[21:16];
          wr_data_r   <= frame_nxt[15:0];
        end
      end else if (sck_fall && cnt_r > `MAC_HEAD_LAST + 5'd1) begin
        out_r <= {out_r[14:0], 1'b0};
      end
    end
  end

endmodule

// ===== rtl/mac_top.v
`timescale 1ns/1ps
`include "mac_regs.vh"

module mac_top (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        reset_pin_n,
  input  wire        undervoltage_lockout,
  input  wire        thermal_shutdown,
  input  wire        chip_select,
  input  wire        serial_clock,
  input  wire        serial_in,
  output wire        serial_out,
  input  wire        focus_zoom_sync,
  output wire        focus_zoom_sync_s,
  input  wire        bridge_ctl_first,
  input  wire        bridge_ctl_second,
  input  wire        alpha_rotating,
  input  wire        beta_rotating,
  input  wire        alpha_step_tick,
  input  wire        beta_step_tick,
  input  wire        normal_pulse_first,
  input  wire        normal_pulse_second,
  output reg         pulse_pin_first,
  output reg         pulse_pin_second,
  output reg  [3:0]  peak_pwm,
  output wire        alpha_output_enable,
  output wire        beta_output_enable,
  output wire        alpha_direction,
  output wire        beta_direction,
  output reg         bridge_out_first,
  output reg         bridge_out_first_oe,
  output reg         bridge_out_second,
  output reg         bridge_out_second_oe,
  output wire        lamp_a_out,
  output wire        lamp_a_oe,
  output wire        lamp_b_out,
  output wire        lamp_b_oe
);

  reg  [2:0]  rstp_r;
  reg  [2:0]  undervoltage_lockout_r;
  reg  [1:0]  tsd_r;
  reg  [1:0]  fz_r;
  reg  [1:0]  in1_r;
  reg  [1:0]  in2_r;
  reg         diag_enable_first_r;
  reg         diag_enable_second_r;
  reg  [4:0]  diag_select_r;
  reg  [4:0]  period_scale_r;
  reg  [1:0]  period_resolution_r;
  reg  [15:0] peak_ab_r;
  reg  [15:0] peak_cd_r;
  reg  [15:0] alpha_ctrl_lamp_b_r;
  reg  [15:0] beta_ctrl_lamp_a_r;
  reg  [2:0]  dc_bridge_control_r;
  reg  [10:0] pwm_cnt_r;
  reg         alpha_mon_r;
  reg         beta_mon_r;
  reg  [15:0] rd_data;
  reg         sel_first;
  reg         sel_second;
  reg         out_first_nxt;
  reg         out_second_nxt;
  reg         oe_first_nxt;
  reg         oe_second_nxt;
  wire [5:0]  rd_addr;
  wire        wr_strobe;
  wire [5:0]  wr_addr;
  wire [15:0] wr_data;
  wire        logic_rst;
  wire        outputs_off;
  wire [10:0] period;
  wire        pwm_clock;

  // ********************************************************
  // on-time at peak, clipped to the whole period
  // ********************************************************
  function [10:0] peak_on_time;
    input [7:0]  width;
    input [1:0]  res;
    input [10:0] per;
    reg   [10:0] raw;
    begin
      raw = {3'b000, width} << res;
      peak_on_time = (raw > per) ? per : raw;
    end
  endfunction

  // ********************************************************
  // pin synchronisers and protection
  // ********************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstp_r <= 3'b000;
      undervoltage_lockout_r <= 3'b111;
      tsd_r  <= 2'b00;
      fz_r   <= 2'b00;
      in1_r  <= 2'b00;
      in2_r  <= 2'b00;
    end else begin
      rstp_r <= {rstp_r[1:0], reset_pin_n};
      undervoltage_lockout_r <= {undervoltage_lockout_r[1:0], undervoltage_lockout};
      tsd_r  <= {tsd_r[0], thermal_shutdown};
      fz_r   <= {fz_r[0], focus_zoom_sync};
      in1_r  <= {in1_r[0], bridge_ctl_first};
      in2_r  <= {in2_r[0], bridge_ctl_second};
    end
  end

  // logic reset is caught one cycle before outputs follow it off
  assign logic_rst   = ~rstp_r[1] | undervoltage_lockout_r[1];
  assign outputs_off = ~rstp_r[2] | undervoltage_lockout_r[2] | tsd_r[1];
  assign focus_zoom_sync_s = fz_r[1];

  // ********************************************************
  // serial register port
  // ********************************************************
  mac_serial u_serial (
    .clock        (clock),
    .reset_n      (reset_n),
    .logic_rst    (logic_rst),
    .chip_select  (chip_select),
    .serial_clock (serial_clock),
    .serial_in    (serial_in),
    .serial_out   (serial_out),
    .rd_addr_r    (rd_addr),
    .rd_data      (rd_data),
    .wr_strobe_r  (wr_strobe),
    .wr_addr_r    (wr_addr),
    .wr_data_r    (wr_data)
  );

  // ********************************************************
  // register file
  // ********************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      diag_enable_first_r  <= 1'b0;
      diag_enable_second_r <= 1'b0;
      diag_select_r        <= 5'h00;
      period_scale_r       <= 5'h00;
      period_resolution_r  <= 2'b00;
      peak_ab_r            <= `MAC_RST_WORD;
      peak_cd_r            <= `MAC_RST_WORD;
      alpha_ctrl_lamp_b_r  <= `MAC_RST_WORD;
      beta_ctrl_lamp_a_r   <= `MAC_RST_WORD;
      dc_bridge_control_r  <= 3'b000;
    end else if (logic_rst) begin
      diag_enable_first_r  <= 1'b0;
      diag_enable_second_r <= 1'b0;
      diag_select_r        <= 5'h00;
      period_scale_r       <= 5'h00;
      period_resolution_r  <= 2'b00;
      peak_ab_r            <= `MAC_RST_WORD;
      peak_cd_r            <= `MAC_RST_WORD;
      alpha_ctrl_lamp_b_r  <= `MAC_RST_WORD;
      beta_ctrl_lamp_a_r   <= `MAC_RST_WORD;
      dc_bridge_control_r  <= 3'b000;
    end else if (wr_strobe) begin
      case (wr_addr)
        `MAC_ADDR_DIAG_EN1:   diag_enable_first_r <= wr_data[`MAC_DIAG_EN_BIT];
        `MAC_ADDR_DIAG_SEL: begin
          diag_enable_second_r <= wr_data[`MAC_DIAG_EN_BIT];
          diag_select_r        <= wr_data[`MAC_DIAG_SEL_MSB:0];
        end
        `MAC_ADDR_PWM_SETUP: begin
          period_scale_r      <= wr_data[`MAC_SCALE_MSB:0];
          period_resolution_r <= wr_data[`MAC_RES_LSB+1:`MAC_RES_LSB];
        end
        `MAC_ADDR_PEAK_AB:    peak_ab_r <= wr_data;
        `MAC_ADDR_PEAK_CD:    peak_cd_r <= wr_data;
        `MAC_ADDR_ALPHA_CTRL: alpha_ctrl_lamp_b_r <= wr_data;
        `MAC_ADDR_BETA_CTRL:  beta_ctrl_lamp_a_r <= wr_data;
        `MAC_ADDR_DC_BRIDGE:  dc_bridge_control_r <= wr_data[2:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rd_data = 16'h0000;
    case (rd_addr)
      `MAC_ADDR_DIAG_EN1:   rd_data[`MAC_DIAG_EN_BIT] = diag_enable_first_r;
      `MAC_ADDR_DIAG_SEL:   rd_data = {8'h00, diag_enable_second_r, 2'b00, diag_select_r};
      `MAC_ADDR_PWM_SETUP:  rd_data = {9'h000, period_resolution_r, period_scale_r};
      `MAC_ADDR_PEAK_AB:    rd_data = peak_ab_r;
      `MAC_ADDR_PEAK_CD:    rd_data = peak_cd_r;
      `MAC_ADDR_ALPHA_CTRL: rd_data = alpha_ctrl_lamp_b_r;
      `MAC_ADDR_BETA_CTRL:  rd_data = beta_ctrl_lamp_a_r;
      `MAC_ADDR_DC_BRIDGE:  rd_data = {13'h0000, dc_bridge_control_r};
      default:              rd_data = 16'h0000;
    endcase
  end

  // ********************************************************
  // pwm period counter and peak-duty outputs
  // ********************************************************
  assign period = {6'h00, period_scale_r} << (`MAC_PWM_UNIT + period_resolution_r);
  assign pwm_clock = (pwm_cnt_r < {1'b0, period[10:1]});

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt_r <= 11'd0;
      peak_pwm  <= 4'h0;
    end else begin
      if (period == 11'd0 || pwm_cnt_r >= period - 11'd1)
        pwm_cnt_r <= 11'd0;
      else
        pwm_cnt_r <= pwm_cnt_r + 11'd1;
      // zero width gives zero on-time, so the coil stays dark
      peak_pwm[3] <= pwm_cnt_r < peak_on_time(peak_ab_r[15:8], period_resolution_r, period);
      peak_pwm[2] <= pwm_cnt_r < peak_on_time(peak_ab_r[7:0], period_resolution_r, period);
      peak_pwm[1] <= pwm_cnt_r < peak_on_time(peak_cd_r[15:8], period_resolution_r, period);
      peak_pwm[0] <= pwm_cnt_r < peak_on_time(peak_cd_r[7:0], period_resolution_r, period);
    end
  end

  // ********************************************************
  // motor enables, forced off by protection, and direction
  // ********************************************************
  assign alpha_output_enable = alpha_ctrl_lamp_b_r[`MAC_OUT_EN_BIT] & ~outputs_off;
  assign beta_output_enable  = beta_ctrl_lamp_a_r[`MAC_OUT_EN_BIT] & ~outputs_off;
  assign alpha_direction     = alpha_ctrl_lamp_b_r[`MAC_DIR_BIT];
  assign beta_direction      = beta_ctrl_lamp_a_r[`MAC_DIR_BIT];

  // ********************************************************
  // diagnostic pulse pins
  // ********************************************************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alpha_mon_r <= 1'b0;
      beta_mon_r  <= 1'b0;
    end else begin
      if (!alpha_rotating)
        alpha_mon_r <= 1'b0;
      else if (alpha_step_tick)
        alpha_mon_r <= ~alpha_mon_r;
      if (!beta_rotating)
        beta_mon_r <= 1'b0;
      else if (beta_step_tick)
        beta_mon_r <= ~beta_mon_r;
    end
  end

  always @* begin
    sel_first  = normal_pulse_first;
    sel_second = normal_pulse_second;
    if (diag_enable_first_r && diag_enable_second_r) begin
      case (diag_select_r)
        `MAC_DIAG_ENABLE: begin
          sel_first  = alpha_ctrl_lamp_b_r[`MAC_OUT_EN_BIT];
          sel_second = beta_ctrl_lamp_a_r[`MAC_OUT_EN_BIT];
        end
        `MAC_DIAG_DIR: begin
          sel_first  = alpha_direction;
          sel_second = beta_direction;
        end
        `MAC_DIAG_STEP_MON: begin
          sel_first  = alpha_mon_r;
          sel_second = beta_mon_r;
        end
        `MAC_DIAG_PWM_MON: begin
          sel_first  = pwm_clock;
          sel_second = 1'b0;
        end
        `MAC_DIAG_BUSY: begin
          sel_first  = alpha_rotating;
          sel_second = beta_rotating;
        end
        default: ;
      endcase
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_pin_first  <= 1'b0;
      pulse_pin_second <= 1'b0;
    end else begin
      pulse_pin_first  <= sel_first;
      pulse_pin_second <= sel_second;
    end
  end

  // ********************************************************
  // dc bridge decode
  // ********************************************************
  always @* begin
    out_first_nxt  = 1'b0;
    out_second_nxt = 1'b0;
    oe_first_nxt   = 1'b1;
    oe_second_nxt  = 1'b1;
    case (dc_bridge_control_r[`MAC_SRC_SEL_BIT] ?
          dc_bridge_control_r[1:0] : {in1_r[1], in2_r[1]})
      2'b00: begin
        oe_first_nxt  = 1'b0;
        oe_second_nxt = 1'b0;
      end
      2'b01:   out_second_nxt = 1'b1;
      2'b10:   out_first_nxt  = 1'b1;
      default: ;
    endcase
    if (outputs_off) begin
      oe_first_nxt  = 1'b0;
      oe_second_nxt = 1'b0;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bridge_out_first     <= 1'b0;
      bridge_out_first_oe  <= 1'b0;
      bridge_out_second    <= 1'b0;
      bridge_out_second_oe <= 1'b0;
    end else begin
      bridge_out_first     <= out_first_nxt;
      bridge_out_first_oe  <= oe_first_nxt;
      bridge_out_second    <= out_second_nxt;
      bridge_out_second_oe <= oe_second_nxt;
    end
  end

  // ********************************************************
  // open-drain lamps: enable pulls the pin low
  // ********************************************************
  assign lamp_a_out = 1'b0;
  assign lamp_b_out = 1'b0;
  assign lamp_a_oe  = beta_ctrl_lamp_a_r[`MAC_LAMP_BIT];
  assign lamp_b_oe  = alpha_ctrl_lamp_b_r[`MAC_LAMP_BIT];

endmodule

// ===== dv/mac_top_asserts.sv
`timescale 1ns/1ps
module mac_top_asserts (
  input logic clock,
  input logic reset_n,
  input logic reset_pin_n,
  input logic undervoltage_lockout,
  input logic thermal_shutdown,
  input logic focus_zoom_sync,
  input logic focus_zoom_sync_s,
  input logic alpha_output_enable,
  input logic beta_output_enable,
  input logic bridge_out_first,
  input logic bridge_out_first_oe,
  input logic bridge_out_second,
  input logic bridge_out_second_oe,
  input logic lamp_a_out,
  input logic lamp_a_oe,
  input logic lamp_b_out,
  input logic lamp_b_oe
);
  // ********************************************************
  // protection, bridge, lamp and sync checks
  // ********************************************************
  logic [2:0] up_cnt_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // cycles since reset release, saturating, keeps the sync check off the reset edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) up_cnt_r <= 3'h0;
    else if (up_cnt_r != 3'h7) up_cnt_r <= up_cnt_r + 3'h1;
  end

  lamp_sink_only_a:
    assert property (!lamp_a_out && !lamp_b_out)
    else $error("lamp output driven high");
  thermal_motor_off_a:
    assert property (thermal_shutdown [*4] |-> !alpha_output_enable && !beta_output_enable)
    else $error("motor enabled during thermal shutdown");
  thermal_bridge_off_a:
    assert property (thermal_shutdown [*4] |-> !bridge_out_first_oe && !bridge_out_second_oe)
    else $error("bridge driven during thermal shutdown");
  bridge_oe_pair_a:
    assert property (bridge_out_first_oe == bridge_out_second_oe)
    else $error("bridge sides disagree on drive");
  bridge_no_high_a:
    assert property (bridge_out_first_oe |-> !(bridge_out_first && bridge_out_second))
    else $error("bridge drives both sides high");
  pin_reset_off_a:
    assert property (!reset_pin_n [*6] |->
      !alpha_output_enable && !beta_output_enable && !lamp_a_oe && !lamp_b_oe)
    else $error("outputs live during reset pin");
  undervoltage_lockout_reset_off_a:
    assert property (undervoltage_lockout [*6] |->
      !alpha_output_enable && !beta_output_enable && !lamp_a_oe && !lamp_b_oe)
    else $error("outputs live during undervoltage");
  sync_copy_a:
    assert property ((up_cnt_r == 3'h7 && $stable(focus_zoom_sync)) [*3] |->
      focus_zoom_sync_s == focus_zoom_sync)
    else $error("sync copy differs from settled input");
endmodule

bind mac_top mac_top_asserts i_mac_top_asserts (
  .clock, .reset_n, .reset_pin_n, .undervoltage_lockout, .thermal_shutdown,
  .focus_zoom_sync, .focus_zoom_sync_s, .alpha_output_enable, .beta_output_enable,
  .bridge_out_first, .bridge_out_first_oe, .bridge_out_second, .bridge_out_second_oe,
  .lamp_a_out, .lamp_a_oe, .lamp_b_out, .lamp_b_oe);

// ===== dv/mac_host.sv
`timescale 1ns/1ps
module mac_host (
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in,
  input  logic serial_out
);
  logic [15:0] rd_q; // last 16 read bits, taken at each rising serial clock
  // ********************************************************
  // host side of the four-wire serial link
  // ********************************************************
  // link idles with clock low and deselected
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end

  // one frame, msb first, n bits; a short n leaves the frame incomplete
  task automatic send(input logic [24:0] frame, input int n);
    #7;
    chip_select = 1'b1;
    for (int i = 24; i > 24 - n; i--) begin
      serial_in = frame[i];
      #80 serial_clock = 1'b1;
      rd_q = {rd_q[14:0], serial_out};
      #80 serial_clock = 1'b0;
    end
    #80 chip_select = 1'b0;
    serial_in = ~serial_in; // stale data is not held after the frame
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "mac_regs.vh"
module tb_top;
  // ********************************************************
  // stimulus, design and checks
  // ********************************************************
  logic       clock, reset_n, reset_pin_n, undervoltage_lockout, thermal_shutdown;
  logic       focus_zoom_sync, bridge_ctl_first, bridge_ctl_second, alpha_rotating;
  logic       beta_rotating, alpha_step_tick, beta_step_tick;
  logic       normal_pulse_first, normal_pulse_second;
  wire        chip_select, serial_clock, serial_in, serial_out, focus_zoom_sync_s;
  wire        pulse_pin_first, pulse_pin_second, alpha_output_enable, beta_output_enable;
  wire        alpha_direction, beta_direction, bridge_out_first, bridge_out_first_oe;
  wire        bridge_out_second, bridge_out_second_oe, lamp_a_out, lamp_a_oe;
  wire        lamp_b_out, lamp_b_oe;
  wire  [3:0] peak_pwm;
  wire  [3:0] bout = {bridge_out_first, bridge_out_first_oe, bridge_out_second,
                      bridge_out_second_oe};
  int         failures = 0;
  int         tests_run = 0;
  int         cycles = 0;
  int         cases [6][3] = '{'{30,1,200}, '{31,2,250}, '{10,0,96}, '{5,0,255},
                               '{4,0,0}, '{3,0,20}};
  logic [4:0] sels [4] = '{`MAC_DIAG_NORMAL, `MAC_DIAG_DIR, `MAC_DIAG_BUSY, `MAC_DIAG_ENABLE};

  mac_host i_host (.chip_select, .serial_clock, .serial_in, .serial_out);
  mac_top i_mac_top (.clock, .reset_n, .reset_pin_n, .undervoltage_lockout, .thermal_shutdown,
    .chip_select, .serial_clock, .serial_in, .serial_out, .focus_zoom_sync,
    .focus_zoom_sync_s, .bridge_ctl_first, .bridge_ctl_second, .alpha_rotating,
    .beta_rotating, .alpha_step_tick, .beta_step_tick, .normal_pulse_first,
    .normal_pulse_second, .pulse_pin_first, .pulse_pin_second, .peak_pwm,
    .alpha_output_enable, .beta_output_enable, .alpha_direction, .beta_direction,
    .bridge_out_first, .bridge_out_first_oe, .bridge_out_second, .bridge_out_second_oe,
    .lamp_a_out, .lamp_a_oe, .lamp_b_out, .lamp_b_oe);

  // 50 mhz oscillator
  always #10 clock = ~clock;

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // advance n cycles, inputs move 1 ns after the edge; sync input wanders
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      if ($urandom_range(3) == 0) focus_zoom_sync = ~focus_zoom_sync;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_host.send({`MAC_CMD_WRITE, a, d}, 25);
    tick(8);
  endtask

  // bridge pins {out1, oe1, out2, oe2} for a control code
  function automatic logic [3:0] bridge(input logic [1:0] c);
    case (c)
      2'b00: return 4'b0000;
      2'b01: return 4'b0111;
      2'b10: return 4'b1101;
      default: return 4'b0101;
    endcase
  endfunction

  // pulse pins for a diag selection; v = {ctrl bits, rotating, normal pulses}
  function automatic logic [1:0] diag(input logic [4:0] sel, input logic [9:0] v);
    case (sel)
      `MAC_DIAG_NORMAL: return v[1:0];
      `MAC_DIAG_ENABLE: return {v[5], v[8]};
      `MAC_DIAG_DIR: return {v[4], v[7]};
      default: return v[3:2];
    endcase
  endfunction

  // on cycles per period: width scaled by resolution, clipped to the period
  function automatic logic [15:0] pwm_on(input int s, input int r, input int w);
    int p;
    p = (s * 8) << r;
    return 16'(((w << r) > p) ? p : (w << r));
  endfunction

  // one period of pin one, counting cycles with all and with any peak output high
  task automatic measure(output logic [15:0] per, output logic [15:0] hi);
    logic q;
    per = 0;
    hi = 0;
    for (int g = 0; g < 4000 && pulse_pin_first !== 1'b0; g++) tick(1);
    for (int g = 0; g < 4000 && pulse_pin_first !== 1'b1; g++) tick(1);
    do begin
      hi += 16'(&peak_pwm) + 16'(|peak_pwm);
      per++;
      q = pulse_pin_first;
      tick(1);
    end while (!(q === 1'b0 && pulse_pin_first === 1'b1) && per < 16'd4000);
  endtask

  // main sequence
  initial begin
    int r, s, rr, w;
    logic [9:0] v;
    logic [1:0] pp;
    logic [15:0] p, h;
    r = $urandom(32'h9bc7);
    clock = 1'b0;
    {reset_n, reset_pin_n, undervoltage_lockout, thermal_shutdown} = 4'b0100;
    {focus_zoom_sync, bridge_ctl_first, bridge_ctl_second, alpha_rotating} = 4'h0;
    {beta_rotating, alpha_step_tick, beta_step_tick} = 3'h0;
    {normal_pulse_first, normal_pulse_second} = 2'h0;
    tick(10);
    reset_n = 1'b1;
    tick(8);
    chk({alpha_output_enable, beta_output_enable, lamp_a_oe, lamp_b_oe}, 0);
    for (int i = 0; i < 4; i++) begin
      {bridge_ctl_first, bridge_ctl_second} = 2'(i);
      tick(4);
      chk(bout, bridge(2'(i)));
    end
    for (int i = 0; i < 4; i++) begin
      {bridge_ctl_first, bridge_ctl_second} = ~2'(i);
      wr(`MAC_ADDR_DC_BRIDGE, {13'h0, 1'b1, 2'(i)});
      chk(bout, bridge(2'(i)));
    end
    i_host.send({`MAC_CMD_WRITE, `MAC_ADDR_DC_BRIDGE, 16'h0004}, 24);
    tick(8);
    chk(bout, bridge(2'b11));
    wr(`MAC_ADDR_DIAG_EN1, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      v = 10'($urandom);
      {alpha_rotating, beta_rotating, normal_pulse_first, normal_pulse_second} = v[3:0];
      wr(`MAC_ADDR_ALPHA_CTRL, {4'h0, v[6], v[5], 1'b0, v[4], 8'h00});
      wr(`MAC_ADDR_BETA_CTRL, {4'h0, v[9], v[8], 1'b0, v[7], 8'h00});
      wr(`MAC_ADDR_DIAG_SEL, {8'h00, 3'h4, sels[i]});
      chk({lamp_a_oe, beta_output_enable, beta_direction, lamp_b_oe, alpha_output_enable,
           alpha_direction}, v[9:4]);
      chk({pulse_pin_first, pulse_pin_second}, diag(sels[i], v));
      i_host.send({`MAC_CMD_READ, `MAC_ADDR_DIAG_SEL, 16'h0000}, 25);
      tick(8);
      chk(i_host.rd_q, {8'h00, 3'h4, sels[i]});
    end
    wr(`MAC_ADDR_DIAG_EN1, 16'h0000);
    chk({pulse_pin_first, pulse_pin_second}, v[1:0]);
    wr(`MAC_ADDR_DIAG_EN1, 16'h0080);
    {alpha_rotating, beta_rotating} = 2'b11;
    wr(`MAC_ADDR_DIAG_SEL, {8'h00, 3'h4, `MAC_DIAG_STEP_MON});
    pp = {pulse_pin_first, pulse_pin_second};
    {alpha_step_tick, beta_step_tick} = 2'b11;
    tick(1);
    {alpha_step_tick, beta_step_tick} = 2'b00;
    tick(3);
    chk({pulse_pin_first, pulse_pin_second}, 2'(~pp));
    {alpha_rotating, beta_rotating} = 2'b00;
    tick(3);
    chk({pulse_pin_first, pulse_pin_second}, 0);
    wr(`MAC_ADDR_DIAG_SEL, {8'h00, 3'h4, `MAC_DIAG_PWM_MON});
    for (int i = 0; i < 7; i++) begin
      s = (i < 6) ? cases[i][0] : 16 + $urandom_range(15);
      rr = (i < 6) ? cases[i][1] : $urandom_range(3);
      w = (i < 6) ? cases[i][2] : $urandom_range(255);
      wr(`MAC_ADDR_PWM_SETUP, {9'h0, 2'(rr), 5'(s)});
      wr(`MAC_ADDR_PEAK_AB, {8'(w), 8'(w)});
      wr(`MAC_ADDR_PEAK_CD, {8'(w), 8'(w)});
      measure(p, h);
      chk(p, 16'((s * 8) << rr));
      chk(h, 16'(2 * pwm_on(s, rr, w)));
      chk(pulse_pin_second, 0);
    end
    wr(`MAC_ADDR_ALPHA_CTRL, 16'h0400);
    wr(`MAC_ADDR_DC_BRIDGE, 16'h0007);
    thermal_shutdown = 1'b1;
    tick(5);
    chk({alpha_output_enable, bridge_out_first_oe}, 0);
    thermal_shutdown = 1'b0;
    tick(5);
    chk({alpha_output_enable, bridge_out_first_oe}, 2'b11);
    for (int i = 0; i < 2; i++) begin
      wr(`MAC_ADDR_ALPHA_CTRL, 16'h0c00);
      chk({alpha_output_enable, lamp_b_oe}, 2'b11);
      {reset_pin_n, undervoltage_lockout} = i ? 2'b00 : 2'b11;
      tick(8);
      {reset_pin_n, undervoltage_lockout} = 2'b10;
      tick(8);
      chk({alpha_output_enable, lamp_b_oe}, 0);
    end
    conclude();
  end
endmodule
